// >>> shared/clkgen_regs.vh
// constants for the motherboard clock output control block
`ifndef CLKGEN_REGS_VH
`define CLKGEN_REGS_VH

`define CTRL_OFFSET          12'h000
`define STATUS_OFFSET        12'h004
`define CTRL_FREQ_SEL_BIT    0
`define STAT_FREQ_SEL_BIT    0
`define STAT_STRAP_DONE_BIT  1
`define STAT_USB_STRAP_BIT   2
`define STAT_PROC_RUN_BIT    3
`define STAT_BUS_RUN_BIT     4
`define STAT_PWR_RUN_BIT     5
`define STAT_SPREAD_BIT      6

`define NCO_W                24
`define INC_PROC_100         24'h800000
`define INC_PROC_66          24'h558106
`define INC_REF_14           24'h1253AF
`define INC_USB_48           24'h3D70A4

`define BUS_DIV_100          2'h3
`define BUS_DIV_66           2'h2
`define BUS_HIGH_100         2'h2
`define BUS_HIGH_66          2'h1

`define SPREAD_SHIFT         14
`define SPREAD_PEAK          8'h52
`define SPREAD_STEP_CYCLES   8'hFF

`define MCLK_PERIOD_NS       10
`define STRAP_WAIT_MS        2
`define STRAP_WAIT_CYCLES    ((`STRAP_WAIT_MS * 1000000) / `MCLK_PERIOD_NS)

`endif

// >>> rtl/nco_toggle.v
// phase accumulator that toggles a clock on every carry
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_regs.vh"

module nco_toggle (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [`NCO_W-1:0] inc,
  output reg               clk_q,
  output reg               rise_q,
  output reg               fall_q
);

  reg  [`NCO_W-1:0] acc_q;
  wire [`NCO_W:0]   sum_d;

  assign sum_d = {1'b0, acc_q} + {1'b0, inc};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= {`NCO_W{1'b0}};
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      acc_q  <= sum_d[`NCO_W-1:0];
      rise_q <= sum_d[`NCO_W] & ~clk_q;
      fall_q <= sum_d[`NCO_W] & clk_q;
      if (sum_d[`NCO_W]) begin
        clk_q <= ~clk_q;
      end
    end
  end

endmodule // nco_toggle

`default_nettype wire

// >>> rtl/clock_output_control.v
// output gating, selection and strap logic of the motherboard clock synthesizer
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_regs.vh"

// Behaviour
// - processor stop low: finish the cycle, hold four processor clocks low after 2-3 clocks
// - processor stop high: restart with a full cycle after 2-3 processor clocks
// - seven gated bus clocks run while bus stop is high, sit at 0 when low
// - bus stop sampled on free bus clock rise, applied from the next cycle
// - free-running bus clock keeps toggling regardless of bus stop
// - spread enable low adds plus or minus one half percent centre spread
// - frequency select picks default 66.8/33.4 MHz (low) or 100/33.3 MHz (high)
// - strap level latched at power-on, then the pin becomes a reference clock
// - selectable output gives 24 MHz for strap high, 48 MHz for strap low
// - both interrupt-controller clocks fixed at 14.318 MHz, stopped only by power-down
// - two reference outputs are fixed 14.318 MHz copies of the reference
// - a dedicated 48 MHz output independent of strap and frequency select
// - eight bus clocks derived from the processor clock, phase-synchronous with it
// - power-down low stops all outputs low, after a full cycle except a 24 MHz selectable output, which can stop mid-high; resumes promptly
// - strap pin three-stated for 2 ms, then latched and enabled as output
module clock_output_control #(
  parameter STRAP_WAIT = `STRAP_WAIT_CYCLES
) (
  input  wire        MCLK,
  input  wire        RST_B,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        PROC_STOP_N,
  input  wire        BUS_STOP_N,
  input  wire        SPREAD_N,
  input  wire        PROC_FREQ_SELECT,
  input  wire        POWER_DOWN_N,
  input  wire        REF_STRAP_PIN_I,
  output wire        REF_STRAP_PIN_O,
  output wire        REF_STRAP_PIN_OE,
  output wire [3:0]  PROC_CLK_OUT,
  output wire        BUS_CLK_FREE_OUT,
  output wire [6:0]  BUS_CLK_GATED_OUT,
  output wire [1:0]  INTC_CLK_OUT,
  output wire [1:0]  REF_CLK_OUT,
  output wire        FIXED_USB_CLK_OUT,
  output wire        SELECTABLE_USB_CLK_OUT
);

  reg         rst_s1_q;
  reg         rst_s2_q;
  wire        rst_n;
  reg  [4:0]  in_s1_q;
  reg  [4:0]  in_s2_q;
  wire        stop_proc_s;
  wire        stop_bus_s;
  wire        spread_s;
  wire        pwr_s;
  wire        freq_pin_s;
  reg         freq_sel_q;
  reg         freq_init_q;
  reg  [7:0]  tri_q;
  reg         tri_up_q;
  reg  [7:0]  tri_div_q;
  wire [`NCO_W-1:0] proc_base;
  wire [31:0] spread_ofs;
  wire [31:0] proc_inc_wide;
  wire [`NCO_W-1:0] proc_inc;
  wire        proc_clk;
  wire        proc_rise;
  wire        proc_fall;
  wire        ref_clk;
  wire        ref_rise;
  wire        ref_fall;
  wire        usb_clk;
  wire        usb_rise;
  wire        usb_fall;
  reg  [1:0]  bus_cnt_q;
  reg         bus_clk_q;
  wire [1:0]  bus_div;
  wire [1:0]  bus_high;
  wire [1:0]  bus_cnt_d;
  wire        bus_clk_d;
  reg  [1:0]  proc_pipe_q;
  reg         proc_en_q;
  reg         bus_smp_q;
  reg         bus_en_q;
  reg         bus_free_en_q;
  reg         ref_en_q;
  reg         usb_en_q;
  reg         half_usb_q;
  reg  [17:0] strap_cnt_q;
  reg         strap_done_q;
  reg         usb_strap_q;
  reg         proc_out_q;
  reg         bus_free_out_q;
  reg         bus_gated_out_q;
  reg         ref_out_q;
  reg         usb_out_q;
  reg         sel_usb_out_q;
  wire        apb_wr;
  wire        hit_ctrl;
  wire        hit_stat;
  wire [31:0] status_word;

  // reset release through two flops
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // control pins come from another part; two flops before any use
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= 5'h1F;
      in_s2_q <= 5'h1F;
    end else begin
      in_s1_q <= {PROC_STOP_N, BUS_STOP_N, SPREAD_N, POWER_DOWN_N, PROC_FREQ_SELECT};
      in_s2_q <= in_s1_q;
    end
  end
  assign stop_proc_s = ~in_s2_q[4];
  assign stop_bus_s  = ~in_s2_q[3];
  assign spread_s    = ~in_s2_q[2];
  assign pwr_s       = in_s2_q[1];
  assign freq_pin_s  = in_s2_q[0];

  // power-up default, taken once the pin synchroniser holds the real level, not its reset 1
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_sel_q  <= 1'b0;
      freq_init_q <= 1'b0;
    end else if (!freq_init_q && (strap_done_q || strap_cnt_q == 18'h00002)) begin
      freq_sel_q  <= freq_pin_s;
      freq_init_q <= 1'b1;
    end else if (apb_wr && hit_ctrl) begin
      freq_sel_q  <= PWDATA[`CTRL_FREQ_SEL_BIT];
    end
  end

  // triangle modulation profile for the centre spread
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tri_q     <= 8'h00;
      tri_up_q  <= 1'b1;
      tri_div_q <= 8'h00;
    end else if (!spread_s) begin
      tri_q     <= 8'h00;
      tri_up_q  <= 1'b1;
      tri_div_q <= 8'h00;
    end else if (tri_div_q == `SPREAD_STEP_CYCLES) begin
      tri_div_q <= 8'h00;
      if (tri_up_q) begin
        tri_q    <= tri_q + 8'h01;
        tri_up_q <= ~($signed(tri_q) == $signed(`SPREAD_PEAK - 8'h01));
      end else begin
        tri_q    <= tri_q - 8'h01;
        tri_up_q <= ($signed(tri_q) == -$signed(`SPREAD_PEAK - 8'h01));
      end
    end else begin
      tri_div_q <= tri_div_q + 8'h01;
    end
  end

  assign proc_base     = freq_sel_q ? `INC_PROC_100 : `INC_PROC_66;
  // offset is base/16384 per step, peak 82 steps, close to half a percent
  assign spread_ofs    = $signed({8'h00, proc_base >> `SPREAD_SHIFT}) *
                         $signed({{24{tri_q[7]}}, tri_q});
  assign proc_inc_wide = {8'h00, proc_base} + spread_ofs;
  assign proc_inc      = proc_inc_wide[`NCO_W-1:0];

  nco_toggle u_proc (
    .clk    (MCLK),
    .rst_n  (rst_n),
    .inc    (proc_inc),
    .clk_q  (proc_clk),
    .rise_q (proc_rise),
    .fall_q (proc_fall)
  );

  nco_toggle u_ref (
    .clk    (MCLK),
    .rst_n  (rst_n),
    .inc    (`INC_REF_14),
    .clk_q  (ref_clk),
    .rise_q (ref_rise),
    .fall_q (ref_fall)
  );

  nco_toggle u_usb (
    .clk    (MCLK),
    .rst_n  (rst_n),
    .inc    (`INC_USB_48),
    .clk_q  (usb_clk),
    .rise_q (usb_rise),
    .fall_q (usb_fall)
  );

  // bus clock counts processor rising edges, so it inherits the spread too
  assign bus_div   = freq_sel_q ? `BUS_DIV_100 : `BUS_DIV_66;
  assign bus_high  = freq_sel_q ? `BUS_HIGH_100 : `BUS_HIGH_66;
  assign bus_cnt_d = (bus_cnt_q >= bus_div - 2'h1) ? 2'h0 : bus_cnt_q + 2'h1;
  assign bus_clk_d = (bus_cnt_d < bus_high);

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_cnt_q <= 2'h0;
      bus_clk_q <= 1'b0;
    end else if (proc_rise) begin
      bus_cnt_q <= bus_cnt_d;
      bus_clk_q <= bus_clk_d;
    end
  end

  // half-rate usb clock for the strap-selected output
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      half_usb_q <= 1'b0;
    end else if (usb_rise) begin
      half_usb_q <= ~half_usb_q;
    end
  end

  // processor stop: two rising edges of pipeline, enable changes only while low
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      proc_pipe_q <= 2'b11;
      proc_en_q   <= 1'b1;
    end else begin
      if (proc_rise) begin
        proc_pipe_q <= {proc_pipe_q[0], ~stop_proc_s & pwr_s};
      end
      if (proc_fall) begin
        proc_en_q <= proc_pipe_q[1];
      end
    end
  end

  // bus stop: sampled on the free clock rise, applied at its falling edge
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_smp_q     <= 1'b1;
      bus_en_q      <= 1'b1;
      bus_free_en_q <= 1'b1;
    end else if (proc_rise && bus_clk_q && !bus_clk_d) begin
      bus_en_q      <= bus_smp_q & pwr_s;
      bus_free_en_q <= pwr_s;
    end else if (proc_rise && !bus_clk_q && bus_clk_d) begin
      bus_smp_q     <= ~stop_bus_s;
    end
  end

  // fixed-rate outputs only stop in power-down, after a low edge except the 24 MHz selectable output, which can stop mid-high
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ref_en_q <= 1'b1;
      usb_en_q <= 1'b1;
    end else begin
      if (ref_fall) begin
        ref_en_q <= pwr_s;
      end
      if (usb_fall) begin
        usb_en_q <= pwr_s;
      end
    end
  end

  // strap window: pin released, then level latched and the driver turned on
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q  <= 18'h00000;
      strap_done_q <= 1'b0;
      usb_strap_q  <= 1'b1;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT[17:0] - 18'h00001) begin
        strap_done_q <= 1'b1;
        usb_strap_q  <= REF_STRAP_PIN_I;
      end else begin
        strap_cnt_q  <= strap_cnt_q + 18'h00001;
      end
    end
  end

  // output flops keep the pins glitch-free
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      proc_out_q      <= 1'b0;
      bus_free_out_q  <= 1'b0;
      bus_gated_out_q <= 1'b0;
      ref_out_q       <= 1'b0;
      usb_out_q       <= 1'b0;
      sel_usb_out_q   <= 1'b0;
    end else begin
      proc_out_q      <= proc_clk & proc_en_q;
      bus_free_out_q  <= bus_clk_q & bus_free_en_q;
      bus_gated_out_q <= bus_clk_q & bus_en_q;
      ref_out_q       <= ref_clk & ref_en_q;
      usb_out_q       <= usb_clk & usb_en_q;
      sel_usb_out_q   <= (usb_strap_q ? half_usb_q : usb_clk) & usb_en_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_out
      if (gi < 4) begin : g_proc
        assign PROC_CLK_OUT[gi] = proc_out_q;
      end
      if (gi < 2) begin : g_fixed
        assign INTC_CLK_OUT[gi] = ref_out_q;
        assign REF_CLK_OUT[gi]  = ref_out_q;
      end
      assign BUS_CLK_GATED_OUT[gi] = bus_gated_out_q;
    end
  endgenerate

  assign BUS_CLK_FREE_OUT       = bus_free_out_q;
  assign FIXED_USB_CLK_OUT      = usb_out_q;
  assign SELECTABLE_USB_CLK_OUT = sel_usb_out_q;
  assign REF_STRAP_PIN_O        = ref_out_q & strap_done_q;
  assign REF_STRAP_PIN_OE       = strap_done_q;

  // zero-wait apb slave; unmapped or misdirected accesses flag an error
  assign apb_wr   = PSEL & PENABLE & PWRITE;
  assign hit_ctrl = (PADDR == `CTRL_OFFSET);
  assign hit_stat = (PADDR == `STATUS_OFFSET);

  assign status_word = {25'h0000000, spread_s, pwr_s, bus_en_q, proc_en_q,
                        usb_strap_q, strap_done_q, freq_sel_q};

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~(hit_ctrl | (hit_stat & ~PWRITE));
  assign PRDATA  = (PSEL & ~PWRITE & hit_ctrl) ? {31'h00000000, freq_sel_q} :
                   (PSEL & ~PWRITE & hit_stat) ? status_word : 32'h00000000;

endmodule // clock_output_control

`default_nettype wire

// >>> test/clock_output_control_properties.sv
// port assertions for the clock output control block
`timescale 1ns/1ps
`default_nettype none
module clock_output_control_properties #(
  parameter STRAP_WAIT = 20
) (
  input wire       MCLK,
  input wire       RST_B,
  input wire       PROC_STOP_N,
  input wire       BUS_STOP_N,
  input wire       POWER_DOWN_N,
  input wire       REF_STRAP_PIN_OE,
  input wire [3:0] PROC_CLK_OUT,
  input wire       BUS_CLK_FREE_OUT,
  input wire [6:0] BUS_CLK_GATED_OUT,
  input wire [1:0] INTC_CLK_OUT
);
  int   ps_q;
  int   bs_q;
  int   up_q;
  int   same_q;
  int   st_q;
  logic fr_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // stop, power-up and strap counters saturate so a long run never wraps into a false pass
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ps_q   <= 0;
      bs_q   <= 0;
      up_q   <= 0;
      same_q <= 0;
      st_q   <= 0;
      fr_q   <= 1'b0;
    end else begin
      ps_q   <= PROC_STOP_N ? 0 : (ps_q < 999 ? ps_q + 1 : ps_q);
      bs_q   <= BUS_STOP_N ? 0 : (bs_q < 999 ? bs_q + 1 : bs_q);
      up_q   <= !POWER_DOWN_N ? 0 : (up_q < 999 ? up_q + 1 : up_q);
      st_q   <= st_q < STRAP_WAIT ? st_q + 1 : st_q;
      fr_q   <= BUS_CLK_FREE_OUT;
      same_q <= (BUS_CLK_FREE_OUT == fr_q) ? same_q + 1 : 0;
    end
  end
  property p_proc_stop; ps_q > 40 |-> PROC_CLK_OUT == 4'h0; endproperty
  a_proc_stop: assert property (p_proc_stop) else $error("proc clocks not stopped");
  property p_proc_same; PROC_CLK_OUT == 4'h0 || PROC_CLK_OUT == 4'hF; endproperty
  a_proc_same: assert property (p_proc_same) else $error("proc copies differ");
  property p_bus_stop; bs_q > 40 |-> BUS_CLK_GATED_OUT == 7'h00; endproperty
  a_bus_stop: assert property (p_bus_stop) else $error("gated bus clocks not low");
  property p_bus_same; BUS_CLK_GATED_OUT[0] |-> BUS_CLK_GATED_OUT == 7'h7F && BUS_CLK_FREE_OUT;
  endproperty
  a_bus_same: assert property (p_bus_same) else $error("gated bus not in step with free");
  property p_free_runs; up_q > 100 |-> same_q < 16; endproperty
  a_free_runs: assert property (p_free_runs) else $error("free bus clock stalled");
  property p_intc; INTC_CLK_OUT[0] == INTC_CLK_OUT[1]; endproperty
  a_intc: assert property (p_intc) else $error("intc copies differ");
  property p_strap_hold; st_q < STRAP_WAIT |-> !REF_STRAP_PIN_OE; endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap pin driven early");
  property p_strap_keep; REF_STRAP_PIN_OE ##1 POWER_DOWN_N |-> REF_STRAP_PIN_OE; endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("strap pin released");
  c_proc_stop: cover property (ps_q == 41);
  c_bus_stop: cover property (bs_q == 41);
  c_strap: cover property ($rose(REF_STRAP_PIN_OE));
endmodule // clock_output_control_properties
`default_nettype wire

// >>> test/chipset_model.sv
// chipset side model driving the stop, spread and power-down pins
`timescale 1ns/1ps
`default_nettype none
module chipset_model (
  input  wire logic       MCLK,
  input  wire logic       slow,
  input  wire logic [3:0] want,
  output var  logic [3:0] pins
);
  logic [3:0] dly_q = 4'hF;
  initial pins = 4'hF;
  // slow mode lags a cycle, like glue logic behind a latch
  always @(posedge MCLK) begin
    dly_q <= want;
    pins  <= slow ? dly_q : want;
  end
endmodule // chipset_model
`default_nettype wire

// >>> test/motherboard_clock_output_control_tb_top.sv
// self-checking bench for the clock output control block
`timescale 1ns/1ps
`default_nettype none
module motherboard_clock_output_control_tb_top;
  localparam int SW = 20;
  localparam int N = 1200;
  logic MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SEL = 1, strap = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [3:0] want = 4'hF, pins, PROC;
  logic [6:0] GATED, mon, prv;
  logic [1:0] INTC, REF;
  logic [15:0] lf = 16'hE127;
  logic PREADY, PSLVERR, OE, PO, FREE, FIX, SELU, err, slow = 1;
  int failures = 0, checked = 0, cyc = 0, cnt[7];
  bit meas = 0;
  // the strap resistor pulls the pin whenever the block lets go of it
  wire pin = (OE === 1'b1) ? PO : strap;
  always #5 MCLK = ~MCLK;
  chipset_model cs (.MCLK(MCLK), .slow(slow), .want(want), .pins(pins));
  clock_output_control #(.STRAP_WAIT(SW)) uut (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PROC_STOP_N(pins[0]), .BUS_STOP_N(pins[1]),
    .SPREAD_N(pins[2]), .PROC_FREQ_SELECT(SEL), .POWER_DOWN_N(pins[3]),
    .REF_STRAP_PIN_I(pin), .REF_STRAP_PIN_O(PO), .REF_STRAP_PIN_OE(OE), .PROC_CLK_OUT(PROC),
    .BUS_CLK_FREE_OUT(FREE), .BUS_CLK_GATED_OUT(GATED), .INTC_CLK_OUT(INTC),
    .REF_CLK_OUT(REF), .FIXED_USB_CLK_OUT(FIX), .SELECTABLE_USB_CLK_OUT(SELU));
  assign mon = {GATED[0], SELU, FIX, REF[0], INTC[0], FREE, PROC[0]};
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    prv <= mon;
    if (meas) foreach (cnt[i]) cnt[i] += (mon[i] !== prv[i]);
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int tog(int khz);
    return khz * N / 200000;
  endfunction
  task automatic chk(string nm, int e, int g);
    checked++;
    if (g > e + 4 || g < e - 4) begin
      failures++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic eq(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // toggle counts over a fixed window against the integer frequency model
  task automatic clocks(int p, int b, int r, int f, int u, int g);
    @(negedge MCLK) cnt = '{default: 0};
    meas = 1;
    repeat (N) @(negedge MCLK);
    meas = 0;
    chk("proc", tog(p), cnt[0]);
    chk("free_bus", tog(b), cnt[1]);
    chk("intc", tog(r), cnt[2]);
    chk("ref", tog(r), cnt[3]);
    chk("fixed_usb", tog(f), cnt[4]);
    chk("sel_usb", tog(u), cnt[5]);
    chk("gated_bus", tog(g), cnt[6]);
  endtask
  task automatic step(int bit_no, logic v);
    @(posedge MCLK);
    want[bit_no] <= v;
    repeat (60) @(posedge MCLK);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    RST_B <= 1;
    repeat (SW + 20) @(posedge MCLK);
    apb(0, 12'h004, 32'h0);
    eq("status", 32'h3B, rd);
    clocks(100000, 33333, 14318, 48000, 48000, 33333);
    lf = nx(lf);
    apb(1, 12'h000, {16'h0, lf[15:1], 1'b0});
    apb(0, 12'h000, 32'h0);
    eq("ctrl", 32'h0, rd);
    clocks(66800, 33400, 14318, 48000, 48000, 33400);
    step(1, 0);
    apb(0, 12'h004, 32'h0);
    eq("bus_run", 32'h0, rd & 32'h10);
    clocks(66800, 33400, 14318, 48000, 48000, 0);
    step(1, 1);
    slow <= 0;
    step(0, 0);
    clocks(0, 33400, 14318, 48000, 48000, 33400);
    step(0, 1);
    clocks(66800, 33400, 14318, 48000, 48000, 33400);
    step(2, 0);
    apb(0, 12'h004, 32'h0);
    eq("spread", 32'h40, rd & 32'h40);
    clocks(66800, 33400, 14318, 48000, 48000, 33400);
    step(2, 1);
    lf = nx(lf);
    apb(1, {1'b1, lf[8:0], 2'b00}, {lf, lf});
    eq("unmapped_err", 32'h1, {31'h0, err});
    apb(0, {1'b1, lf[8:0], 2'b00}, 32'h0);
    eq("unmapped_rd", 32'h1, {rd[30:0], err});
    apb(1, 12'h004, 32'hFFFFFFFF);
    eq("status_wr", 32'h1, {31'h0, err});
    step(3, 0);
    clocks(0, 0, 0, 0, 0, 0);
    step(3, 1);
    clocks(66800, 33400, 14318, 48000, 48000, 33400);
    @(posedge MCLK);
    RST_B <= 0;
    strap <= 1;
    SEL <= 0;
    repeat (16) @(posedge MCLK);
    RST_B <= 1;
    repeat (SW + 20) @(posedge MCLK);
    apb(0, 12'h004, 32'h0);
    eq("status_strap", 32'h3E, rd);
    clocks(66800, 33400, 14318, 48000, 24000, 33400);
    conclude();
  end
endmodule // motherboard_clock_output_control_tb_top
bind clock_output_control clock_output_control_properties #(.STRAP_WAIT(STRAP_WAIT)) chk (
  .MCLK(MCLK), .RST_B(RST_B), .PROC_STOP_N(PROC_STOP_N), .BUS_STOP_N(BUS_STOP_N),
  .POWER_DOWN_N(POWER_DOWN_N), .REF_STRAP_PIN_OE(REF_STRAP_PIN_OE),
  .PROC_CLK_OUT(PROC_CLK_OUT), .BUS_CLK_FREE_OUT(BUS_CLK_FREE_OUT),
  .BUS_CLK_GATED_OUT(BUS_CLK_GATED_OUT), .INTC_CLK_OUT(INTC_CLK_OUT));
`default_nettype wire
